// File: rtl/fss_pkg.sv
// Functional notes
// - Summary byte command answers one byte.
// - Summary word command answers two bytes.
// - Word low byte is the byte storage.
// - Summary bits other than 7, 6 and 11 follow detail registers only.
// - Bit 7 flags a busy-declared fault.
// - Writing 80h or 0080h clears busy.
// - Writing 0180h clears busy and unknown-command.
// - Bit 6 live: not converting power.
// - Bit 5: output overvoltage fault occurred.
// - Bit 4: output overcurrent fault occurred.
// - Bit 3: input undervoltage fault occurred.
// - Bit 2: any temperature fault or warning.
// - Bit 1: communication, memory or logic fault.
// - Bit 0: fault not covered by byte.
// - Bit 15: any output-voltage detail fault.
// - Bit 14: any output-current detail fault.
// - Bit 13: any input detail fault.
// - Bit 12: any vendor detail fault.
// - Bit 11 live copy of power-good pin.
// - Bit 9: miscellaneous detail fault occurred.
// - Bits 10 and 8 read zero.
// - Every alert-capable bit has a mask bit.
// - Detail clears make summary bits fall.
package fss_pkg;
    localparam logic [7:0]  CMD_SUMMARY_BYTE  = 8'h78;
    localparam logic [7:0]  CMD_SUMMARY_WORD  = 8'h79;
    localparam logic [7:0]  CMD_ALERT_MASK    = 8'h1b;
    localparam logic [15:0] CLR_BUSY_BYTE     = 16'h0080;
    localparam logic [15:0] CLR_BUSY_WORD     = 16'h0080;
    localparam logic [15:0] CLR_BUSY_UNKNOWN  = 16'h0180;
    localparam int          BIT_BUSY          = 7;
    localparam int          BIT_OFF           = 6;
    localparam int          BIT_OUT_OV        = 5;
    localparam int          BIT_OUT_OC        = 4;
    localparam int          BIT_IN_UV         = 3;
    localparam int          BIT_TEMP          = 2;
    localparam int          BIT_CML           = 1;
    localparam int          BIT_UNLISTED      = 0;
    localparam int          BIT_OUTPUT_VOLTAGE_GROUP_SUMMARY_GRP      = 15;
    localparam int          BIT_OUTPUT_CURRENT_GROUP_SUMMARY_GRP      = 14;
    localparam int          BIT_INPUT_GRP     = 13;
    localparam int          BIT_VENDOR        = 12;
    localparam int          BIT_POWER_GOOD_LIVE         = 11;
    localparam int          BIT_OTHER         = 9;
    localparam int          DET_OV_FAULT_POS  = 7;
    localparam int          DET_OC_FAULT_POS  = 7;
    localparam int          DET_IN_UV_POS     = 4;
    localparam logic [15:0] SUMMARY_RESET     = 16'h0000;
    localparam logic [15:0] MASK_RESET        = 16'h0000;
    localparam logic [15:0] UNSUPPORTED_BITS  = 16'h0500;
    localparam logic [15:0] LIVE_BITS         = 16'h0840;
    localparam int          PG_SYNC_STAGES    = 3;
endpackage

// File: rtl/fss_detail_if.sv
`timescale 1ns/10ps
interface fss_detail_if;
    logic [7:0]  output_voltage_group_summary_det;
    logic [7:0]  output_current_group_summary_det;
    logic [7:0]  input_det;
    logic [7:0]  temp_det;
    logic [7:0]  cml_det;
    logic [7:0]  other_det;
    logic [7:0]  vendor_det;
    logic        off_live;
    logic        pg_live;
    logic [15:0] word_calc;
    modport src  (output output_voltage_group_summary_det, output_current_group_summary_det, input_det, temp_det, cml_det, other_det,
                  vendor_det, off_live, pg_live, input word_calc);
    modport calc (input output_voltage_group_summary_det, output_current_group_summary_det, input_det, temp_det, cml_det, other_det,
                  vendor_det, off_live, pg_live, output word_calc);
endinterface

// File: rtl/fss_summary.sv
`timescale 1ns/10ps
module fss_summary
    import fss_pkg::*;
(
    // Detail sources and summary result
    fss_detail_if.calc det
);
    function automatic logic any_set(input logic [7:0] v);
        any_set = |v;
    endfunction

    logic [7:0] output_voltage_group_summary_rest;
    logic [7:0] output_current_group_summary_rest;
    logic [7:0] input_rest;

    always_comb begin
        output_voltage_group_summary_rest                  = det.output_voltage_group_summary_det;
        output_current_group_summary_rest                  = det.output_current_group_summary_det;
        input_rest                 = det.input_det;
        output_voltage_group_summary_rest[DET_OV_FAULT_POS] = 1'b0;
        output_current_group_summary_rest[DET_OC_FAULT_POS] = 1'b0;
        input_rest[DET_IN_UV_POS]   = 1'b0;
    end

    always_comb begin
        det.word_calc                = SUMMARY_RESET;
        det.word_calc[BIT_OFF]       = det.off_live;
        det.word_calc[BIT_OUT_OV]    = det.output_voltage_group_summary_det[DET_OV_FAULT_POS];
        det.word_calc[BIT_OUT_OC]    = det.output_current_group_summary_det[DET_OC_FAULT_POS];
        det.word_calc[BIT_IN_UV]     = det.input_det[DET_IN_UV_POS];
        det.word_calc[BIT_TEMP]      = any_set(det.temp_det);
        det.word_calc[BIT_CML]       = any_set(det.cml_det);
        det.word_calc[BIT_UNLISTED]  = any_set(output_voltage_group_summary_rest) | any_set(output_current_group_summary_rest)
                                     | any_set(input_rest) | any_set(det.vendor_det)
                                     | any_set(det.other_det);
        det.word_calc[BIT_OUTPUT_VOLTAGE_GROUP_SUMMARY_GRP]  = any_set(det.output_voltage_group_summary_det);
        det.word_calc[BIT_OUTPUT_CURRENT_GROUP_SUMMARY_GRP]  = any_set(det.output_current_group_summary_det);
        det.word_calc[BIT_INPUT_GRP] = any_set(det.input_det);
        det.word_calc[BIT_VENDOR]    = any_set(det.vendor_det);
        det.word_calc[BIT_POWER_GOOD_LIVE]     = det.pg_live;
        det.word_calc[BIT_OTHER]     = any_set(det.other_det);
    end
endmodule

// File: rtl/fss_top.sv
`timescale 1ns/10ps
module fss_top
    import fss_pkg::*;
#(
    parameter int SYNC_STAGES = PG_SYNC_STAGES
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Command port from the transaction decoder
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        cmd_is_word,
    input  wire logic [15:0] cmd_wdata,
    // Read answer
    output logic             rd_valid,
    output logic             rd_miss,
    output logic [15:0]      rd_data,
    // Detail register contents
    input  wire logic [7:0]  output_voltage_group_summary_detail,
    input  wire logic [7:0]  output_current_group_summary_detail,
    input  wire logic [7:0]  input_detail,
    input  wire logic [7:0]  temp_detail,
    input  wire logic [7:0]  cml_detail,
    input  wire logic [7:0]  other_detail,
    input  wire logic [7:0]  vendor_detail,
    // Live conditions and events
    input  wire logic        not_converting,
    input  wire logic        power_good_live_pin,
    input  wire logic        busy_event,
    // Outputs to the rest of the device
    output logic [15:0]      summary_word,
    output logic             unknown_clear,
    output logic             alert_n
);
    // Elaboration check: the pin filter is built for exactly three stages
    if (SYNC_STAGES != 3) begin : g_bad_sync
        $error("SYNC_STAGES must be 3");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power-good pin synchroniser

    logic       pg_meta_reg;
    logic       pg_s2_reg;
    logic       pg_s3_reg;
    logic       pg_state_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pg_meta_reg <= 1'b0;
            pg_s2_reg   <= 1'b0;
            pg_s3_reg   <= 1'b0;
        end else begin
            pg_meta_reg <= power_good_live_pin;
            pg_s2_reg   <= pg_meta_reg;
            pg_s3_reg   <= pg_s2_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pg_state_reg <= 1'b0;
        end else if (pg_s2_reg == pg_s3_reg) begin
            pg_state_reg <= pg_s3_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Summary decode

    fss_detail_if det_if ();

    assign det_if.output_voltage_group_summary_det   = output_voltage_group_summary_detail;
    assign det_if.output_current_group_summary_det   = output_current_group_summary_detail;
    assign det_if.input_det  = input_detail;
    assign det_if.temp_det   = temp_detail;
    assign det_if.cml_det    = cml_detail;
    assign det_if.other_det  = other_detail;
    assign det_if.vendor_det = vendor_detail;
    assign det_if.off_live   = not_converting;
    assign det_if.pg_live    = pg_state_reg;

    fss_summary u_summary (
        .det (det_if.calc)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode

    logic        wr_byte_hit;
    logic        wr_word_hit;
    logic        busy_clear;
    logic        unknown_clear_next;
    logic        mask_write;

    always_comb begin
        wr_byte_hit        = cmd_wr && !cmd_is_word && (cmd_code == CMD_SUMMARY_BYTE);
        wr_word_hit        = cmd_wr && cmd_is_word && (cmd_code == CMD_SUMMARY_WORD);
        busy_clear         = (wr_byte_hit && cmd_wdata[7:0] == CLR_BUSY_BYTE[7:0])
                           || (wr_word_hit && cmd_wdata == CLR_BUSY_WORD)
                           || (wr_word_hit && cmd_wdata == CLR_BUSY_UNKNOWN);
        unknown_clear_next = wr_word_hit && (cmd_wdata == CLR_BUSY_UNKNOWN);
        mask_write         = cmd_wr && cmd_is_word && (cmd_code == CMD_ALERT_MASK);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Summary storage; low byte is the byte register itself

    logic [15:0] word_reg;
    logic [15:0] word_next;
    logic        busy_next;

    always_comb begin
        if (busy_event) begin
            busy_next = 1'b1;
        end else if (busy_clear) begin
            busy_next = 1'b0;
        end else begin
            busy_next = word_reg[BIT_BUSY];
        end
        word_next           = det_if.word_calc & ~UNSUPPORTED_BITS;
        word_next[BIT_BUSY] = busy_next;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_reg <= SUMMARY_RESET;
        end else begin
            word_reg <= word_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unknown_clear <= 1'b0;
        end else begin
            unknown_clear <= unknown_clear_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Alert mask and alert output

    logic [15:0] mask_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_reg <= MASK_RESET;
        end else if (mask_write) begin
            mask_reg <= cmd_wdata & ~UNSUPPORTED_BITS & ~LIVE_BITS;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_n <= 1'b1;
        end else begin
            alert_n <= ~|(word_next & ~mask_reg & ~LIVE_BITS);
        end
    end

    assign summary_word = word_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Read answer

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_miss  <= 1'b0;
            rd_data  <= 16'h0000;
        end else begin
            rd_valid <= cmd_rd;
            rd_miss  <= 1'b0;
            rd_data  <= 16'h0000;
            if (cmd_rd) begin
                if (!cmd_is_word && cmd_code == CMD_SUMMARY_BYTE) begin
                    rd_data <= {8'h00, word_reg[7:0]};
                end else if (cmd_is_word && cmd_code == CMD_SUMMARY_WORD) begin
                    rd_data <= word_reg;
                end else if (cmd_is_word && cmd_code == CMD_ALERT_MASK) begin
                    rd_data <= mask_reg;
                end else begin
                    rd_miss <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_busy_sets: assert property (
        busy_event |=> summary_word[BIT_BUSY])
        else $error("busy flag not set after busy event");

    chk_busy_clear: assert property (
        (busy_clear && !busy_event) |=> !summary_word[BIT_BUSY])
        else $error("busy flag not cleared by clear write");

    chk_busy_hold: assert property (
        (!busy_event && !busy_clear) |=> summary_word[BIT_BUSY] == $past(summary_word[BIT_BUSY]))
        else $error("busy flag changed without cause");

    chk_unknown_pulse: assert property (
        (cmd_wr && cmd_is_word && cmd_code == CMD_SUMMARY_WORD
         && cmd_wdata == CLR_BUSY_UNKNOWN) |=> unknown_clear ##1 !unknown_clear)
        else $error("unknown clear pulse wrong");

    chk_byte_read: assert property (
        (cmd_rd && !cmd_is_word && cmd_code == CMD_SUMMARY_BYTE)
        |=> rd_valid && !rd_miss && rd_data == {8'h00, $past(summary_word[7:0])})
        else $error("byte read answer wrong");

    chk_word_read: assert property (
        (cmd_rd && cmd_is_word && cmd_code == CMD_SUMMARY_WORD)
        |=> rd_valid && rd_data == $past(summary_word))
        else $error("word read answer wrong");

    chk_ov_follows: assert property (
        ##1 summary_word[BIT_OUT_OV] == $past(output_voltage_group_summary_detail[DET_OV_FAULT_POS]))
        else $error("overvoltage summary does not follow detail");

    chk_off_live: assert property (
        ##1 summary_word[BIT_OFF] == $past(not_converting))
        else $error("off bit not live");

    chk_zero_bits: assert property (
        summary_word[10] == 1'b0 && summary_word[8] == 1'b0)
        else $error("unsupported bit set");

    chk_temp_any: assert property (
        ##1 summary_word[BIT_TEMP] == $past(|temp_detail))
        else $error("temperature summary wrong");

    chk_pg_track: assert property (
        $stable(power_good_live_pin) [*4] |=> summary_word[BIT_POWER_GOOD_LIVE] == $past(power_good_live_pin))
        else $error("power-good bit does not track pin");

    chk_alert_mask: assert property (
        (mask_reg[BIT_OUT_OV] && !busy_event && summary_word == 16'h0020)
        |-> alert_n || $past(word_next != 16'h0020))
        else $error("masked bit raised alert");

    cov_busy_cleared: cover property (busy_event ##[1:20] busy_clear);
    cov_word_clear:   cover property (unknown_clear);
    cov_miss:         cover property (rd_miss);
    cov_alert:        cover property (!alert_n ##1 alert_n);
endmodule

// File: dv/fss_detail_model.sv
`timescale 1ns/10ps
module fss_detail_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Fault injection and host clears
    input  wire logic       set_stb,
    input  wire logic       clr_stb,
    input  wire logic [2:0] sel,
    input  wire logic [7:0] val,
    input  wire logic       unk_set,
    input  wire logic       unknown_clear,
    // Detail contents
    output logic [7:0]      det [7],
    output logic            unk_flag
);
    ////////////////////////////////////////////////////////////////////////
    // Latched detail flags, write-one-to-clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 7; i++) det[i] <= 8'h00;
        end else if (set_stb) begin
            det[sel] <= det[sel] | val;
        end else if (clr_stb) begin
            det[sel] <= det[sel] & ~val;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Unknown-command flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unk_flag <= 1'b0;
        end else if (unk_set) begin
            unk_flag <= 1'b1;
        end else if (unknown_clear) begin
            unk_flag <= 1'b0;
        end
    end
endmodule

// File: dv/fss_top_tb.sv
`timescale 1ns/10ps
module fss_top_tb;
    import fss_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_wr = 1'b0;
    logic        cmd_rd = 1'b0;
    logic [7:0]  cmd_code = 8'h00;
    logic        cmd_is_word = 1'b0;
    logic [15:0] cmd_wdata = 16'h0000;
    logic        rd_valid, rd_miss, unknown_clear, alert_n, unk_flag;
    logic [15:0] rd_data, summary_word;
    logic        not_conv = 1'b0;
    logic        pg_pin = 1'b0;
    logic        busy_ev = 1'b0;
    logic        set_stb = 1'b0;
    logic        clr_stb = 1'b0;
    logic        unk_set = 1'b0;
    logic [2:0]  sel = 3'h0;
    logic [7:0]  val = 8'h00;
    logic [7:0]  det [7];
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    logic [2:0]  sel_t [9] = '{0, 0, 1, 2, 2, 3, 4, 5, 6};
    logic [7:0]  val_t [9] = '{8'h80, 8'h40, 8'h80, 8'h10, 8'h80, 8'h01, 8'h02, 8'h01, 8'h04};
    logic [15:0] exp_t [9] = '{16'h8020, 16'h8001, 16'h4010, 16'h2008, 16'h2001,
                               16'h0004, 16'h0002, 16'h0201, 16'h1001};

    always #5 clk = ~clk;

    fss_top #(.SYNC_STAGES(3)) uut (
        .clk(clk), .rst(rst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
        .cmd_is_word(cmd_is_word), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid),
        .rd_miss(rd_miss), .rd_data(rd_data), .output_voltage_group_summary_detail(det[0]), .output_current_group_summary_detail(det[1]),
        .input_detail(det[2]), .temp_detail(det[3]), .cml_detail(det[4]),
        .other_detail(det[5]), .vendor_detail(det[6]), .not_converting(not_conv),
        .power_good_live_pin(pg_pin), .busy_event(busy_ev), .summary_word(summary_word),
        .unknown_clear(unknown_clear), .alert_n(alert_n));

    fss_detail_model model (
        .clk(clk), .rst(rst), .set_stb(set_stb), .clr_stb(clr_stb), .sel(sel), .val(val),
        .unk_set(unk_set), .unknown_clear(unknown_clear), .det(det), .unk_flag(unk_flag));

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        wt(1);
        s = 1'b0;
    endtask
    task automatic setd(input logic [2:0] s, input logic [7:0] v);
        sel = s;
        val = v;
        pulse(set_stb);
    endtask
    task automatic clrd(input logic [2:0] s, input logic [7:0] v);
        sel = s;
        val = v;
        pulse(clr_stb);
    endtask
    task automatic wr(input logic [7:0] c, input logic w, input logic [15:0] d);
        cmd_code = c;
        cmd_is_word = w;
        cmd_wdata = d;
        pulse(cmd_wr);
        wt(2);
    endtask
    task automatic rdchk(input logic [7:0] c, input logic w, input logic [15:0] e,
                         input logic em);
        int n;
        n = 0;
        cmd_code = c;
        cmd_is_word = w;
        pulse(cmd_rd);
        while (rd_valid !== 1'b1 && n < 3) begin
            wt(1);
            n++;
        end
        chk({15'h0000, rd_valid}, 16'h0001);
        chk(rd_data, e);
        chk({15'h0000, rd_miss}, {15'h0000, em});
        wt(1);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        wt(12);
        rst = 1'b0;
        wt(2);
        chk(summary_word, SUMMARY_RESET);
        chk({15'h0000, alert_n}, 16'h0001);
        rdchk(CMD_SUMMARY_WORD, 1'b1, 16'h0000, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            setd(sel_t[i], val_t[i]);
            wt(3);
            rdchk(CMD_SUMMARY_WORD, 1'b1, exp_t[i], 1'b0);
            rdchk(CMD_SUMMARY_BYTE, 1'b0, {8'h00, exp_t[i][7:0]}, 1'b0);
            wr(CMD_SUMMARY_WORD, 1'b1, 16'h7f7f);
            wr(CMD_SUMMARY_BYTE, 1'b0, 16'h007f);
            chk(summary_word, exp_t[i]);
            clrd(sel_t[i], val_t[i]);
            wt(3);
            rdchk(CMD_SUMMARY_WORD, 1'b1, 16'h0000, 1'b0);
        end
        $display("test summary map done");
        not_conv = 1'b1;
        wt(2);
        rdchk(CMD_SUMMARY_WORD, 1'b1, 16'h0040, 1'b0);
        pg_pin = 1'b1;
        wt(6);
        rdchk(CMD_SUMMARY_WORD, 1'b1, 16'h0840, 1'b0);
        not_conv = 1'b0;
        pg_pin = 1'b0;
        wt(6);
        rdchk(CMD_SUMMARY_WORD, 1'b1, 16'h0000, 1'b0);
        $display("test live bits done");
        pulse(busy_ev);
        wt(2);
        rdchk(CMD_SUMMARY_BYTE, 1'b0, 16'h0080, 1'b0);
        wr(CMD_SUMMARY_BYTE, 1'b0, 16'h00ff);
        wr(CMD_SUMMARY_WORD, 1'b0, CLR_BUSY_BYTE);
        rdchk(CMD_SUMMARY_WORD, 1'b1, 16'h0080, 1'b0);
        wr(CMD_SUMMARY_BYTE, 1'b0, CLR_BUSY_BYTE);
        rdchk(CMD_SUMMARY_BYTE, 1'b0, 16'h0000, 1'b0);
        pulse(busy_ev);
        wr(CMD_SUMMARY_WORD, 1'b1, CLR_BUSY_WORD);
        rdchk(CMD_SUMMARY_WORD, 1'b1, 16'h0000, 1'b0);
        pulse(busy_ev);
        pulse(unk_set);
        wr(CMD_SUMMARY_WORD, 1'b1, CLR_BUSY_UNKNOWN);
        rdchk(CMD_SUMMARY_WORD, 1'b1, 16'h0000, 1'b0);
        chk({15'h0000, unk_flag}, 16'h0000);
        $display("test busy clear done");
        rdchk(8'h7a, 1'b0, 16'h0000, 1'b1);
        rdchk(CMD_SUMMARY_WORD, 1'b0, 16'h0000, 1'b1);
        rdchk(CMD_SUMMARY_BYTE, 1'b1, 16'h0000, 1'b1);
        $display("test unmapped done");
        setd(3, 8'h01);
        wt(3);
        chk({15'h0000, alert_n}, 16'h0000);
        wr(CMD_ALERT_MASK, 1'b1, 16'h0004);
        wt(1);
        chk({15'h0000, alert_n}, 16'h0001);
        rdchk(CMD_ALERT_MASK, 1'b1, 16'h0004, 1'b0);
        wr(CMD_ALERT_MASK, 1'b1, 16'h0000);
        wt(1);
        chk({15'h0000, alert_n}, 16'h0000);
        clrd(3, 8'h01);
        wt(3);
        chk({15'h0000, alert_n}, 16'h0001);
        $display("test alert mask done");
        test_done();
    end
endmodule
